/* File: swrs_regs.svh */
// constants and behaviour list for the supply watchdog reset supervisor
// Behaviour
// - Output stays on while enable is high, or with enable low while kicks are valid.
// - Enable low and kicks invalid switches the output off and enters sleep.
// - A failed watchdog gives a repeating reset pulse train until valid kicks return.
// - The watchdog timeout period is a parameter scaled from the timing setting.
// - Each watchdog reset pulse lasts a parameter duration scaled from the timing setting.
// - An undervoltage lasting over 2.0 us asserts reset; shorter dips are ignored.
// - Reset is held asserted through the power-up delay.
// - A kick input outside its valid level range counts as watchdog failure.
// - Kicks between 96 Hz and 100 kHz never cause a spurious reset.
// - One timing setting derives the timeout, pulse repetition and power-on delay.
// - An input overvoltage fault turns the output off.
// - An over-temperature fault turns the output pass stage off.
// - After undervoltage, reset holds until regulation returns and the power-on delay ends; failed kicks then give the pulse train.
// - Reset is active low and open-drain, only ever pulled low.
`ifndef SWRS_REGS_SVH
`define SWRS_REGS_SVH
`define SWRS_CLK_HZ 50000000
`define SWRS_UV_FILTER_NS 2000
// least time rounds up
`define SWRS_UV_FILTER_CYC ((`SWRS_UV_FILTER_NS * (`SWRS_CLK_HZ / 1000000) + 999) / 1000)
// timing setting in nanofarads, default 0.1 uF
`define SWRS_CDELAY_NF 100
// factors per farad: 1.3e5, 1.0e4, 4.75e5 -> ms per nF scaled by 1e3 (us per nF)
`define SWRS_WDT_US_PER_NF 130
`define SWRS_RST_US_PER_NF 10
`define SWRS_POR_US_PER_NF 475
`define SWRS_CNT_W 32
`endif

/* File: swrs_pkg.sv */
// types for the supply watchdog reset supervisor
package swrs_pkg;
  typedef enum logic [1:0] {
    SWRS_POR,
    SWRS_RUN,
    SWRS_WD_PULSE,
    SWRS_WD_GAP
  } swrs_state_e;
  typedef logic [31:0] swrs_cnt_t;
endpackage

/* File: swrs_top.sv */
// supply watchdog reset supervisor control logic
`timescale 1ns/1ns
`include "swrs_regs.svh"
module swrs_top #(
  parameter logic [31:0] WDT_CYC = 32'(`SWRS_WDT_US_PER_NF * `SWRS_CDELAY_NF * 50),
  parameter logic [31:0] RST_CYC = 32'(`SWRS_RST_US_PER_NF * `SWRS_CDELAY_NF * 50),
  parameter logic [31:0] POR_CYC = 32'(`SWRS_POR_US_PER_NF * `SWRS_CDELAY_NF * 50)
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic watchdog_kick_input_in,
  input wire logic kick_level_ok_in,
  input wire logic undervoltage_in,
  input wire logic overvoltage_fault_in,
  input wire logic overtemp_fault_in,
  output logic reset_n_o_out,
  output logic reset_n_oe_out,
  output logic regulated_output_on_out,
  output logic sleep_out
);
  localparam logic [31:0] UV_CYC = 32'(`SWRS_UV_FILTER_CYC);

  // two-stage synchronisers for all pin inputs except the clock and rst_n_in
  logic [5:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  logic kick_s, lvl_s, en_s, uv_s, ov_s, ot_s;
  always_comb begin
    sync1_nxt = {enable_in, watchdog_kick_input_in, kick_level_ok_in,
                 undervoltage_in, overvoltage_fault_in, overtemp_fault_in};
    sync2_nxt = sync1_r;
  end
  // synchronised async inputs
  // level-ok resets high so reset release is not mistaken for a bad kick level
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 6'h08;
      sync2_r <= 6'h08;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end
  assign {en_s, kick_s, lvl_s, uv_s, ov_s, ot_s} = sync2_r;

  // watchdog timeout counter, restarted by each kick edge
  logic kick_d_r, kick_d_nxt;
  swrs_pkg::swrs_cnt_t wd_cnt_r, wd_cnt_nxt;
  logic wd_fail_r, wd_fail_nxt;
  logic kick_edge;
  assign kick_edge = kick_s ^ kick_d_r;
  always_comb begin
    kick_d_nxt = kick_s;
    wd_cnt_nxt = wd_cnt_r;
    wd_fail_nxt = wd_fail_r;
    if (!lvl_s) begin
      wd_cnt_nxt = 32'h0;
      wd_fail_nxt = 1'b1;
    end else if (kick_edge) begin
      wd_cnt_nxt = 32'h0;
      wd_fail_nxt = 1'b0;
    end else if (wd_cnt_r >= WDT_CYC - 32'h1) begin
      wd_fail_nxt = 1'b1;
    end else begin
      wd_cnt_nxt = wd_cnt_r + 32'h1;
    end
  end
  // fail starts clear so that a fresh power-up is judged by the por delay first
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kick_d_r <= 1'b0;
      wd_cnt_r <= 32'h0;
      wd_fail_r <= 1'b0;
    end else begin
      kick_d_r <= kick_d_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_fail_r <= wd_fail_nxt;
    end
  end

  // undervoltage glitch filter
  swrs_pkg::swrs_cnt_t uv_cnt_r, uv_cnt_nxt;
  logic uv_hit_r, uv_hit_nxt;
  always_comb begin
    uv_cnt_nxt = 32'h0;
    uv_hit_nxt = 1'b0;
    if (uv_s) begin
      uv_cnt_nxt = (uv_cnt_r > UV_CYC) ? uv_cnt_r : uv_cnt_r + 32'h1;
      uv_hit_nxt = (uv_cnt_r >= UV_CYC);
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uv_cnt_r <= 32'h0;
      uv_hit_r <= 1'b0;
    end else begin
      uv_cnt_r <= uv_cnt_nxt;
      uv_hit_r <= uv_hit_nxt;
    end
  end

  // reset sequencer: power-on delay, run, pulse train
  swrs_pkg::swrs_state_e st_r, st_nxt;
  swrs_pkg::swrs_cnt_t tm_r, tm_nxt;
  logic rst_low_r, rst_low_nxt;
  logic out_on;
  always_comb begin
    st_nxt = st_r;
    tm_nxt = tm_r + 32'h1;
    if (uv_hit_r || !out_on) begin
      st_nxt = swrs_pkg::SWRS_POR;
      tm_nxt = 32'h0;
    end else begin
      case (st_r)
        swrs_pkg::SWRS_POR: begin
          if (tm_r >= POR_CYC - 32'h1) begin
            tm_nxt = 32'h0;
            st_nxt = wd_fail_r ? swrs_pkg::SWRS_WD_PULSE : swrs_pkg::SWRS_RUN;
          end
        end
        swrs_pkg::SWRS_RUN: begin
          tm_nxt = 32'h0;
          if (wd_fail_r) begin
            st_nxt = swrs_pkg::SWRS_WD_PULSE;
          end
        end
        swrs_pkg::SWRS_WD_PULSE: begin
          if (tm_r >= RST_CYC - 32'h1) begin
            tm_nxt = 32'h0;
            st_nxt = swrs_pkg::SWRS_WD_GAP;
          end
        end
        swrs_pkg::SWRS_WD_GAP: begin
          if (!wd_fail_r) begin
            st_nxt = swrs_pkg::SWRS_RUN;
            tm_nxt = 32'h0;
          end else if (tm_r >= WDT_CYC - 32'h1) begin
            st_nxt = swrs_pkg::SWRS_WD_PULSE;
            tm_nxt = 32'h0;
          end
        end
        default: begin
          st_nxt = swrs_pkg::SWRS_POR;
          tm_nxt = 32'h0;
        end
      endcase
    end
    rst_low_nxt = (st_nxt != swrs_pkg::SWRS_RUN) && (st_nxt != swrs_pkg::SWRS_WD_GAP);
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= swrs_pkg::SWRS_POR;
      tm_r <= 32'h0;
      rst_low_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      tm_r <= tm_nxt;
      rst_low_r <= rst_low_nxt;
    end
  end

  // output stage and sleep decision
  logic sleep_r, sleep_nxt;
  always_comb begin
    // sleep when both are missing
    // sleep is sticky until enable returns; kicks cannot revive an unpowered processor
    sleep_nxt = (!en_s && wd_fail_r) || (sleep_r && !en_s);
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end
  assign out_on = !sleep_r && !ov_s && !ot_s;
  assign regulated_output_on_out = out_on;
  assign sleep_out = sleep_r;
  assign reset_n_o_out = 1'b0;
  assign reset_n_oe_out = rst_low_r;

  // no reset while kicks keep coming
  property p_no_spurious;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_RUN && kick_edge && lvl_s && !uv_hit_r && out_on)
      |=> !rst_low_r;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("spurious reset");

  property p_por_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_POR) |-> reset_n_oe_out;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset not held in power-up");

  property p_uv_reset;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    uv_hit_r |=> (st_r == swrs_pkg::SWRS_POR) && rst_low_r;
  endproperty
  a_uv_reset: assert property (p_uv_reset) else $error("undervoltage missed");

  property p_short_dip;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(uv_s) |=> !uv_hit_r [*3];
  endproperty
  a_short_dip: assert property (p_short_dip) else $error("dip not filtered");

  property p_fail_pulse;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_RUN && wd_fail_r && !uv_hit_r && out_on) |=> rst_low_r;
  endproperty
  a_fail_pulse: assert property (p_fail_pulse) else $error("no pulse on failure");

  property p_level_fail;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !lvl_s |=> wd_fail_r;
  endproperty
  a_level_fail: assert property (p_level_fail) else $error("bad level not failure");

  property p_faults_off;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (ov_s || ot_s) |-> !regulated_output_on_out;
  endproperty
  a_faults_off: assert property (p_faults_off) else $error("output on during fault");

  property p_enable_on;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (en_s && !ov_s && !ot_s) |=> (!ov_s && !ot_s) |-> regulated_output_on_out;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("output off with enable");

  property p_sleep;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (!en_s && wd_fail_r) |=> sleep_out && !regulated_output_on_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_edge_restart;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (kick_edge && lvl_s) |=> (wd_cnt_r == 32'h0) && !wd_fail_r;
  endproperty
  a_edge_restart: assert property (p_edge_restart) else $error("kick did not restart");

  property p_od_low;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    reset_n_o_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("reset pin driven high");

  property p_pulse_end;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_WD_PULSE && tm_r >= RST_CYC - 32'h1 && !uv_hit_r && out_on)
      |=> (st_r == swrs_pkg::SWRS_WD_GAP) && !rst_low_r;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

  property p_gap_repeat;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_WD_GAP && wd_fail_r && tm_r >= WDT_CYC - 32'h1 && !uv_hit_r && out_on)
      |=> (st_r == swrs_pkg::SWRS_WD_PULSE) && rst_low_r;
  endproperty
  a_gap_repeat: assert property (p_gap_repeat) else $error("train did not repeat");

  property p_gap_exit;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_WD_GAP && !wd_fail_r && !uv_hit_r && out_on)
      |=> (st_r == swrs_pkg::SWRS_RUN);
  endproperty
  a_gap_exit: assert property (p_gap_exit) else $error("train did not stop");

  property p_wd_expire;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (lvl_s && !kick_edge && wd_cnt_r >= WDT_CYC - 32'h1) |=> wd_fail_r;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("timeout not detected");

  // no hit before the filter count
  property p_uv_filter;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (uv_cnt_r < UV_CYC) |=> !uv_hit_r;
  endproperty
  a_uv_filter: assert property (p_uv_filter) else $error("undervoltage hit too early");

  property p_wake;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (sleep_out && en_s) |=> !sleep_out;
  endproperty
  a_wake: assert property (p_wake) else $error("enable did not wake");

  // delay end with valid kicks releases reset
  property p_por_exit;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_r == swrs_pkg::SWRS_POR && tm_r >= POR_CYC - 32'h1 && !wd_fail_r && !uv_hit_r && out_on)
      |=> (st_r == swrs_pkg::SWRS_RUN) && !rst_low_r;
  endproperty
  a_por_exit: assert property (p_por_exit) else $error("reset not released after delay");
endmodule

/* File: swrs_uproc_model.sv */
// kick source standing in for the supervised processor
`timescale 1ns/1ns
module swrs_uproc_model (
  input wire logic sys_clk_in,
  input wire logic run_in,
  input wire logic [7:0] half_in,
  output logic kick_out
);
  logic [7:0] cnt_r = 8'h00;
  initial kick_out = 1'b0;
  // keep kicking
  // a halted processor leaves the pin still, so no edge can sneak through
  always @(posedge sys_clk_in) begin
    if (run_in && cnt_r >= half_in) begin
      cnt_r <= 8'h00;
      kick_out <= #1 ~kick_out;
    end else if (run_in) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

/* File: test_supply_watchdog_reset_supervisor.sv */
// self-checking bench for the supervisor control logic
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_supply_watchdog_reset_supervisor;
  localparam int WDT = 200;
  localparam int RST = 20;
  localparam int POR = 300;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic kok = 1'b1;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic ot = 1'b0;
  logic run = 1'b1;
  logic [7:0] half = 8'h09;
  logic kick;
  logic rst_o;
  logic oe;
  logic on;
  logic slp;
  logic seen;
  int n_fail = 0;
  int checks = 0;
  int cyc_n = 0;
  int w;
  // short counts keep the run brief; expectations all follow them
  swrs_top #(.WDT_CYC(32'(WDT)), .RST_CYC(32'(RST)), .POR_CYC(32'(POR))) dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .enable_in(en), .watchdog_kick_input_in(kick),
    .kick_level_ok_in(kok), .undervoltage_in(uv), .overvoltage_fault_in(ov),
    .overtemp_fault_in(ot), .reset_n_o_out(rst_o), .reset_n_oe_out(oe),
    .regulated_output_on_out(on), .sleep_out(slp));
  swrs_uproc_model cpu (.sys_clk_in(clk), .run_in(run), .half_in(half), .kick_out(kick));
  always #10 clk = ~clk;
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // wait bounded for reset to reach a level
  task automatic wait_oe(input logic v, input int lim);
    int i;
    i = 0;
    while (oe !== v && i < lim) begin
      cyc(1);
      i++;
    end
    `CHK("reset level", v, oe)
  endtask
  task automatic width(input logic v);
    w = 0;
    while (oe === v && w < 1000) begin
      cyc(1);
      w++;
    end
  endtask
  // watch for any reset over a stretch
  task automatic quiet(input int n);
    seen = 1'b0;
    repeat (n) begin
      cyc(1);
      if (oe !== 1'b0) seen = 1'b1;
    end
  endtask
  task automatic t_por();
    cyc(POR - 50);
    `CHK("por hold", 1'b1, oe)
    wait_oe(1'b0, 80);
    `CHK("pin data", 1'b0, rst_o)
    $display("test por done");
  endtask
  task automatic t_wd();
    half = 8'h01;
    quiet(3 * WDT);
    `CHK("fast kicks", 1'b0, seen)
    run = 1'b0;
    wait_oe(1'b1, WDT + 10);
    width(1'b1);
    `CHK("pulse len", 1'b1, w >= RST - 2 && w <= RST + 2)
    width(1'b0);
    `CHK("gap len", 1'b1, w >= WDT - 3 && w <= WDT + 3)
    `CHK("pulse again", 1'b1, oe)
    run = 1'b1;
    wait_oe(1'b0, RST + 10);
    quiet(2 * WDT);
    `CHK("train stops", 1'b0, seen)
    kok = 1'b0;
    wait_oe(1'b1, WDT + 10);
    kok = 1'b1;
    wait_oe(1'b0, RST + WDT + 10);
    $display("test watchdog done");
  endtask
  task automatic t_uv();
    uv = 1'b1;
    cyc(50);
    uv = 1'b0;
    quiet(20);
    `CHK("short dip", 1'b0, seen)
    uv = 1'b1;
    cyc(150);
    `CHK("long dip", 1'b1, oe)
    uv = 1'b0;
    cyc(POR - 60);
    `CHK("uv hold", 1'b1, oe)
    wait_oe(1'b0, 100);
    $display("test undervoltage done");
  endtask
  task automatic t_fault();
    ov = 1'b1;
    cyc(5);
    `CHK("ov off", 1'b0, on)
    ov = 1'b0;
    ot = 1'b1;
    cyc(5);
    `CHK("ot off", 1'b0, on)
    ot = 1'b0;
    cyc(5);
    `CHK("fault clear", 1'b1, on)
    wait_oe(1'b0, POR + 20);
    $display("test fault done");
  endtask
  task automatic t_sleep();
    en = 1'b0;
    cyc(2 * WDT);
    `CHK("en low kicks", 1'b1, on)
    `CHK("awake", 1'b0, slp)
    run = 1'b0;
    w = 0;
    while (slp !== 1'b1 && w < 2 * WDT + RST + 20) begin
      cyc(1);
      w++;
    end
    `CHK("sleep", 1'b1, slp)
    `CHK("sleep off", 1'b0, on)
    en = 1'b1;
    run = 1'b1;
    cyc(5);
    `CHK("wake", 1'b1, on)
    $display("test sleep done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(20);
    rst_n = 1'b1;
    t_por();
    t_wd();
    t_uv();
    t_fault();
    t_sleep();
    summarize();
  end
endmodule
